/* core/dspic_top.sv */
// DSP interrupt controller: pending logic, priority dispatch, status stack
`timescale 1ns/1ps
module dspic_top (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // Register port
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // External pins and internal events
   input wire dspic_pkg::dspic_pins_type PINS_I,
   input wire dspic_pkg::dspic_ireq_type IREQ_I,
   output logic FLAG_OUTPUT_ALT_O,
   // Program sequencer
   output logic REQ_O,
   output logic [13:0] VECTOR_O,
   input wire logic ACK_I,
   input wire logic PUSH_I,
   input wire logic POP_I
);
   import dspic_pkg::*;

   logic [NSRC-1:0] mask_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [7:0] mode_status_register_r;
   logic gie_r;
   logic blk_r;
   logic [31:0] rdata_r;
   dspic_pins_type pin_s1_r, pin_s2_r;
   logic [NSRC-1:0] raw, lvl, raw_q_r, pend_r, req, elig;
   logic [NSRC-1:0] force_bits, clear_bits;
   logic req_r;
   logic [3:0] idx_r, sel, cur_level_r;
   logic valid;
   logic [13:0] vec_r;
   logic [11:0] stack_r [STK_DEPTH];
   logic [4:0] sp_r;
   logic wr_mask, wr_ctrl, wr_fc, wr_gie, wr_mode_status_register, ack_take, push, pop;

   // Register write decodes
   assign wr_mask = WR_I && (ADDR_I == OFS_MASK);
   assign wr_ctrl = WR_I && (ADDR_I == OFS_CTRL);
   assign wr_fc = WR_I && (ADDR_I == OFS_FC);
   assign wr_gie = WR_I && (ADDR_I == OFS_GIE);
   assign wr_mode_status_register = WR_I && (ADDR_I == OFS_MODE_STATUS_REGISTER);
   assign ack_take = req_r && ACK_I;
   assign force_bits = wr_fc ? WDATA_I[FC_FORCE_LSB +: NSRC] : '0;
   assign clear_bits = wr_fc ? WDATA_I[FC_CLEAR_LSB +: NSRC] : '0;

   // Two-flop synchroniser; only stage two is looked at
   always_ff @(posedge CLK_SYS_I) begin
      pin_s1_r <= PINS_I;
      pin_s2_r <= pin_s1_r;
   end

   // Raw active-high requests per source index
   always_comb begin
      raw = '0;
      raw[SRC_PWRUP] = IREQ_I.power_up && ctrl_r[CTRL_POWERUP_CONTEXT_RESET_BIT];
      raw[SRC_PWRDN] = IREQ_I.power_down;
      raw[SRC_ELA] = ~pin_s2_r.edge_level_irq_a_n;
      raw[SRC_LA] = ~pin_s2_r.level_irq_a_n;
      raw[SRC_LB] = ~pin_s2_r.level_irq_b_n;
      raw[SRC_SP0TX] = IREQ_I.sp0_tx;
      raw[SRC_SP0RX] = IREQ_I.sp0_rx;
      raw[SRC_EIF] = ~pin_s2_r.edge_irq_forceable_n;
      raw[SRC_BYTE_DMA_PORT] = IREQ_I.byte_dma_port;
      raw[SRC_TIMER] = IREQ_I.timer;
      // Alternate pins take over serial port one slots
      if (ctrl_r[CTRL_SP1_ALT]) begin
         raw[SRC_SP1TX] = ~pin_s2_r.alt_irq_tx_n;
         raw[SRC_SP1RX] = ~pin_s2_r.alt_irq_rx_n;
      end else begin
         raw[SRC_SP1TX] = IREQ_I.sp1_tx;
         raw[SRC_SP1RX] = IREQ_I.sp1_rx;
      end
   end

   // Level-sensitivity per source; everything else latches edges
   always_comb begin
      lvl = '0;
      lvl[SRC_ELA] = ~ctrl_r[CTRL_ELA_EDGE];
      lvl[SRC_LA] = 1'b1;
      lvl[SRC_LB] = 1'b1;
      lvl[SRC_EIF] = 1'b0;
      lvl[SRC_SP1TX] = ctrl_r[CTRL_SP1_ALT] && ~ctrl_r[CTRL_ATX_EDGE];
      lvl[SRC_SP1RX] = ctrl_r[CTRL_SP1_ALT] && ~ctrl_r[CTRL_ARX_EDGE];
   end

   // Previous raw value for edge detection
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         raw_q_r <= '0;
      end else begin
         raw_q_r <= raw;
      end
   end

   // Per-source pending latch, request and eligibility
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_src
         logic set_b, clr_b, unmask_b, gate_b;
         assign set_b = (raw[gi] && !raw_q_r[gi] && !lvl[gi])
                        || force_bits[gi];
         assign clr_b = clear_bits[gi] || (ack_take && idx_r == 4'(gi));
         // Set beats clear so a fresh edge is never lost
         always_ff @(posedge CLK_SYS_I) begin
            if (RST_I) begin
               pend_r[gi] <= 1'b0;
            end else if (set_b) begin
               pend_r[gi] <= 1'b1;
            end else if (clr_b) begin
               pend_r[gi] <= 1'b0;
            end
         end
         // Level inputs follow the pin; forcing still works on them
         assign req[gi] = pend_r[gi] || (lvl[gi] && raw[gi]);
         // Power-up and power-down ignore the mask
         assign unmask_b = (gi <= SRC_PWRDN) ? 1'b1 : mask_r[gi];
         // Nesting lets only higher levels in, else wait for idle
         assign gate_b = ctrl_r[CTRL_NEST] ? (4'(gi) < cur_level_r)
                         : (cur_level_r == LVL_NONE);
         // Power-up context reset bypasses all gating like reset does
         assign elig[gi] = req[gi] && unmask_b && ((gi == SRC_PWRUP)
                           || (gie_r && !blk_r && gate_b));
      end
   endgenerate

   // Fixed priority: lowest index wins
   always_comb begin
      sel = 4'h0;
      valid = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            sel = 4'(i);
            valid = 1'b1;
         end
      end
   end

   // Request to the sequencer, reselected every cycle until taken
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         req_r <= 1'b0;
         idx_r <= 4'h0;
         vec_r <= VEC_TABLE[SRC_PWRUP];
      end else begin
         // Drop on the acknowledge so one request is never taken twice
         req_r <= valid && !ack_take;
         if (!ack_take) begin
            idx_r <= sel;
            vec_r <= VEC_TABLE[sel];
         end
      end
   end

   // Mask register; reset masks every maskable source
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         mask_r <= MASK_RST;
      end else if (wr_mask) begin
         mask_r <= {WDATA_I[NSRC-1:SRC_PWRDN+1], 2'b00};
      end
   end

   // One-cycle blackout after a mask write; DMA is not stalled
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         blk_r <= 1'b0;
      end else begin
         blk_r <= wr_mask;
      end
   end

   // Control register
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= WDATA_I[CTRL_W-1:0];
      end
   end

   // Global enable; only gates dispatch, transfers keep running
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         gie_r <= GIE_RST;
      end else if (wr_gie && WDATA_I[GIE_DIS]) begin
         gie_r <= 1'b0;
      end else if (wr_gie && WDATA_I[GIE_ENA]) begin
         gie_r <= 1'b1;
      end
   end

   // Shared stack: interrupts, loops and calls all push here
   assign push = (ack_take || PUSH_I) && (sp_r != SP_FULL);
   assign pop = POP_I && !ack_take && !PUSH_I && (sp_r != 5'h00);

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         sp_r <= 5'h00;
      end else if (push) begin
         sp_r <= sp_r + 5'h01;
      end else if (pop) begin
         sp_r <= sp_r - 5'h01;
      end
   end

   // Stack storage holds mode status and the level being serviced
   always_ff @(posedge CLK_SYS_I) begin
      if (push) begin
         stack_r[sp_r[3:0]] <= {mode_status_register_r, cur_level_r};
      end
   end

   // Current service level; a full stack refuses a new level
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         cur_level_r <= LVL_NONE;
      end else if (ack_take && push) begin
         cur_level_r <= idx_r;
      end else if (pop) begin
         cur_level_r <= stack_r[sp_r[3:0] - 4'h1][3:0];
      end
   end

   // Mode status register, restored on every pop
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         mode_status_register_r <= MODE_STATUS_REGISTER_RST;
      end else if (pop) begin
         mode_status_register_r <= stack_r[sp_r[3:0] - 4'h1][11:4];
      end else if (wr_mode_status_register) begin
         mode_status_register_r <= WDATA_I[7:0];
      end
   end

   // Read data stand one cycle; force/clear reads zero
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= 32'h0000_0000;
         if (RD_I) begin
            case (ADDR_I)
               OFS_MASK: rdata_r[NSRC-1:0] <= mask_r;
               OFS_CTRL: rdata_r[CTRL_W-1:0] <= ctrl_r;
               OFS_GIE: rdata_r[GIE_ENA] <= gie_r;
               OFS_MODE_STATUS_REGISTER: rdata_r[7:0] <= mode_status_register_r;
               OFS_STAT: begin
                  rdata_r[NSRC-1:0] <= req;
                  rdata_r[STAT_LVL_LSB +: 4] <= cur_level_r;
                  rdata_r[STAT_SP_LSB +: 5] <= sp_r;
                  rdata_r[STAT_FIN] <= pin_s2_r.flag_input_alt;
               end
               default: rdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Alternate flag output follows its control bit
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         FLAG_OUTPUT_ALT_O <= 1'b0;
      end else begin
         FLAG_OUTPUT_ALT_O <= ctrl_r[CTRL_FOUT];
      end
   end

   assign RDATA_O = rdata_r;
   assign REQ_O = req_r;
   assign VECTOR_O = vec_r;

   // Checks on dispatch, gating and reset state
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   mask_blackout_a: assert property (wr_mask |=> ##1
      (!req_r || idx_r == 4'(SRC_PWRUP)))
      else $error("request raised during mask blackout");

   global_off_a: assert property (!gie_r |=>
      (!req_r || idx_r == 4'(SRC_PWRUP)))
      else $error("request raised while globally disabled");

   vector_match_a: assert property (req_r |->
      vec_r == VEC_TABLE[idx_r])
      else $error("vector does not match source");

   ack_drop_a: assert property (ack_take |=> !req_r)
      else $error("request held after acknowledge");

   ack_level_a: assert property (ack_take && sp_r != SP_FULL |=>
      cur_level_r == $past(idx_r) && sp_r == $past(sp_r) + 5'h01)
      else $error("acknowledge did not push and take level");

   reset_state_a: assert property ($past(RST_I) |->
      gie_r && mask_r == MASK_RST && sp_r == 5'h00
      && mode_status_register_r == MODE_STATUS_REGISTER_RST)
      else $error("wrong state after reset");

   force_pend_a: assert property (wr_fc && WDATA_I[SRC_EIF] |=>
      pend_r[SRC_EIF])
      else $error("force did not set pending");

   no_nest_a: assert property (!ctrl_r[CTRL_NEST] &&
      cur_level_r != LVL_NONE |=> (!req_r || idx_r == 4'(SRC_PWRUP)))
      else $error("nested dispatch with nesting off");

   fc_read_a: assert property (RD_I && ADDR_I == OFS_FC |=>
      RDATA_O == 32'h0000_0000)
      else $error("force/clear register readable");

   // Mask of the cycle that chose the source, indexed by the chosen source
   masked_out_a: assert property (req_r && idx_r > 4'(SRC_PWRDN) |->
      ($past(mask_r) & (12'h001 << idx_r)) != 12'h000)
      else $error("masked source dispatched");

   edge_latch_a: assert property (
      raw[SRC_EIF] && !raw_q_r[SRC_EIF] |=> pend_r[SRC_EIF])
      else $error("edge on forceable input not latched");

   level_nolatch_a: assert property (
      !force_bits[SRC_LB] && !pend_r[SRC_LB] |=> !pend_r[SRC_LB])
      else $error("level input latched a request");

   clear_pend_a: assert property (
      clear_bits[SRC_EIF] && !force_bits[SRC_EIF]
      && !(raw[SRC_EIF] && !raw_q_r[SRC_EIF]) |=> !pend_r[SRC_EIF])
      else $error("clear did not drop pending");

   // Mask bits for power-down read zero, so this also checks the bypass
   pwrdn_unmask_a: assert property (
      pend_r[SRC_PWRDN] && gie_r && !blk_r && !ack_take
      && cur_level_r == LVL_NONE |=> req_r)
      else $error("power-down request held back");

   pop_count_a: assert property (pop |=>
      sp_r == $past(sp_r) - 5'h01)
      else $error("pop did not drop stack pointer");

   stack_full_a: assert property (
      sp_r == SP_FULL && !pop |=> sp_r == SP_FULL)
      else $error("push beyond twelve entries");

   reset_idle_a: assert property ($past(RST_I) |->
      !req_r && vec_r == VEC_TABLE[SRC_PWRUP]
      && cur_level_r == LVL_NONE && pend_r == '0)
      else $error("request or level left after reset");
endmodule

/* core/dspic_pkg.sv */
// Constants, source map and pin bundles for the DSP interrupt controller
package dspic_pkg;
   // Sources: reset-style power-up plus eleven interrupt levels
   localparam int NSRC = 12;
   localparam int STK_DEPTH = 12;
   localparam logic [3:0] LVL_NONE = 4'hC;
   localparam logic [4:0] SP_FULL = 5'h0C;

   // Source indices, lowest index has the highest priority
   localparam int SRC_PWRUP = 0;
   localparam int SRC_PWRDN = 1;
   localparam int SRC_ELA = 2;
   localparam int SRC_LA = 3;
   localparam int SRC_LB = 4;
   localparam int SRC_SP0TX = 5;
   localparam int SRC_SP0RX = 6;
   localparam int SRC_EIF = 7;
   localparam int SRC_BYTE_DMA_PORT = 8;
   localparam int SRC_SP1TX = 9;
   localparam int SRC_SP1RX = 10;
   localparam int SRC_TIMER = 11;

   // Vector per source index
   localparam logic [13:0] VEC_TABLE [NSRC] = '{
      14'h0000, 14'h002C, 14'h0004, 14'h0008, 14'h000C, 14'h0010,
      14'h0014, 14'h0018, 14'h001C, 14'h0020, 14'h0024, 14'h0028};

   // Register offsets
   localparam logic [7:0] OFS_MASK = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_FC = 8'h08;
   localparam logic [7:0] OFS_GIE = 8'h0C;
   localparam logic [7:0] OFS_MODE_STATUS_REGISTER = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;

   // Control register fields
   localparam int CTRL_NEST = 0;
   localparam int CTRL_ELA_EDGE = 1;
   localparam int CTRL_ARX_EDGE = 2;
   localparam int CTRL_ATX_EDGE = 3;
   localparam int CTRL_SP1_ALT = 4;
   localparam int CTRL_POWERUP_CONTEXT_RESET_BIT = 5;
   localparam int CTRL_FOUT = 6;
   localparam int CTRL_W = 7;

   // Force/clear register fields, global enable command bits
   localparam int FC_FORCE_LSB = 0;
   localparam int FC_CLEAR_LSB = 16;
   localparam int GIE_ENA = 0;
   localparam int GIE_DIS = 1;

   // Status register fields
   localparam int STAT_LVL_LSB = 12;
   localparam int STAT_SP_LSB = 16;
   localparam int STAT_FIN = 21;

   // Reset values
   localparam logic [NSRC-1:0] MASK_RST = 12'h000;
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
   localparam logic [7:0] MODE_STATUS_REGISTER_RST = 8'h00;
   localparam logic GIE_RST = 1'b1;

   // External pins, active low interrupts
   typedef struct packed {
      logic edge_level_irq_a_n;
      logic level_irq_a_n;
      logic level_irq_b_n;
      logic edge_irq_forceable_n;
      logic alt_irq_rx_n;
      logic alt_irq_tx_n;
      logic flag_input_alt;
   } dspic_pins_type;

   // Internal one-cycle event requests
   typedef struct packed {
      logic power_up;
      logic power_down;
      logic sp0_tx;
      logic sp0_rx;
      logic byte_dma_port;
      logic sp1_tx;
      logic sp1_rx;
      logic timer;
   } dspic_ireq_type;
endpackage

/* verification/dspic_seq_model.sv */
// Behavioural program sequencer that accepts vectored requests
`timescale 1ns/1ps
module dspic_seq_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Request from the controller
   input wire logic req_i,
   input wire logic [13:0] vec_i,
   // Accept latency chosen by the bench
   input wire logic [7:0] dly_i,
   // Accept strobe and record of what was taken
   output logic ack_o,
   output logic [13:0] last_vec_o,
   output logic [7:0] n_ack_o
);
   int wait_r;

   // Accept after dly_i cycles of request; a slow accept lets the
   // controller reselect a higher-priority vector before it is taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         wait_r <= 0;
         last_vec_o <= 14'h0000;
         n_ack_o <= 8'h00;
      end else begin
         ack_o <= 1'b0;
         // Vector is recorded at the edge where the accept is sampled;
         // an accept that meets a dropped request takes nothing
         if (ack_o && req_i) begin
            last_vec_o <= vec_i;
            n_ack_o <= n_ack_o + 8'h01;
         end
         // Accept only while a request stands, never twice in a row
         if (req_i && !ack_o) begin
            if (wait_r >= dly_i) begin
               ack_o <= 1'b1;
               wait_r <= 0;
            end else begin
               wait_r <= wait_r + 1;
            end
         end else begin
            wait_r <= 0;
         end
      end
   end
endmodule

/* verification/testbench.sv */
// Self-checking testbench for the DSP interrupt controller
`timescale 1ns/1ps
module testbench;
   import dspic_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic push = 1'b0;
   logic pop_s = 1'b0;
   dspic_pins_type pins = 7'h7F; // Unused pins idle high
   dspic_ireq_type ireq = 8'h00;
   logic [31:0] rdata;
   logic flag_out;
   logic req;
   logic ack;
   logic [13:0] vec;
   logic [13:0] last_vec;
   logic [7:0] n_ack;
   logic [31:0] rv;
   logic [7:0] dly = 8'h00;
   int err_count = 0;
   int compares = 0;
   logic [13:0] exp_vec [10] = '{14'h0004, 14'h0008, 14'h000C,
      14'h0010, 14'h0014, 14'h0018, 14'h001C, 14'h0020, 14'h0024,
      14'h0028};

   // Clock at 125 MHz
   always #4 clk = ~clk;

   dspic_top i_dspic_top (.CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .PINS_I(pins), .IREQ_I(ireq), .FLAG_OUTPUT_ALT_O(flag_out),
      .REQ_O(req), .VECTOR_O(vec), .ACK_I(ack), .PUSH_I(push),
      .POP_I(pop_s));

   dspic_seq_model i_dspic_seq_model (.clk_i(clk), .rst_i(rst),
      .req_i(req), .vec_i(vec), .dly_i(dly), .ack_o(ack),
      .last_vec_o(last_vec), .n_ack_o(n_ack));

   // Single comparison point for all results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg,
            got, exp);
      end
   endtask

   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd32(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // One-cycle rising event on an internal request bit
   task automatic ev(input int b);
      @(posedge clk);
      ireq[b] <= 1'b1;
      @(posedge clk);
      ireq[b] <= 1'b0;
   endtask

   // Wait for the sequencer to take a request, then check its vector
   task automatic serve(input logic [13:0] exp, input bit do_pop);
      logic [7:0] n0;
      n0 = n_ack;
      for (int i = 0; i < 40 && n_ack == n0; i++) begin
         @(posedge clk);
         #1;
      end
      chk({24'h00_0000, n_ack - n0}, 32'h0000_0001, "accept count");
      chk({18'h0_0000, last_vec}, {18'h0_0000, exp}, "vector");
      if (do_pop)
         pop();
   endtask

   // Return from handler after the request source has settled
   task automatic pop();
      repeat (4) @(posedge clk);
      pop_s <= 1'b1;
      @(posedge clk);
      pop_s <= 1'b0;
   endtask

   // No request may appear during the given number of cycles
   task automatic quiet(input int c);
      logic seen;
      seen = 1'b0;
      repeat (c) begin
         @(posedge clk);
         #1 seen = seen | req;
      end
      chk({31'h0000_0000, seen}, 32'h0000_0000, "stray request");
   endtask

   task automatic t_reset();
      rd32(OFS_MASK, rv);
      chk(rv, 32'h0000_0000, "mask reset");
      rd32(OFS_GIE, rv);
      chk(rv, 32'h0000_0001, "global enable reset");
      rd32(OFS_MODE_STATUS_REGISTER, rv);
      chk(rv, 32'h0000_0000, "mode status reset");
      rd32(OFS_STAT, rv);
      chk(rv, 32'h0020_C000, "status reset");
      wr32(OFS_FC, 32'h0000_0004);
      rd32(OFS_FC, rv);
      chk(rv, 32'h0000_0000, "force reads zero");
      wr32(8'h40, 32'hFFFF_FFFF);
      rd32(8'h40, rv);
      chk(rv, 32'h0000_0000, "unmapped");
      quiet(6);
      // Fill the shared stack, one push more than it holds
      repeat (13) begin
         @(posedge clk);
         push <= 1'b1;
      end
      @(posedge clk);
      push <= 1'b0;
      rd32(OFS_STAT, rv);
      chk({27'h000_0000, rv[20:16]}, 32'h0000_000C, "stack full");
      repeat (12) pop();
   endtask

   // All maskable sources at once come out in fixed order
   task automatic t_prio();
      wr32(OFS_MASK, 32'h0000_0FFC);
      wr32(OFS_FC, 32'h0000_0FFC);
      for (int i = 0; i < 10; i++)
         serve(exp_vec[i], 1'b1);
   endtask

   // Masked level input, then a mask write with its blackout cycle
   task automatic t_mask();
      wr32(OFS_MASK, 32'h0000_0000);
      @(posedge clk);
      pins.level_irq_a_n <= 1'b0;
      quiet(8);
      wr32(OFS_MASK, 32'h0000_0008);
      quiet(1);
      serve(14'h0008, 1'b0);
      @(posedge clk);
      pins.level_irq_a_n <= 1'b1;
      pop();
   endtask

   // Only the forced serial source is unmasked; power-down ignores the mask
   task automatic t_gie();
      wr32(OFS_MASK, 32'h0000_0020);
      wr32(OFS_GIE, 32'h0000_0002);
      rd32(OFS_GIE, rv);
      chk(rv, 32'h0000_0000, "global disabled");
      wr32(OFS_FC, 32'h0000_0020);
      ev(6);
      quiet(8);
      wr32(OFS_GIE, 32'h0000_0001);
      serve(14'h002C, 1'b1);
      serve(14'h0010, 1'b1);
      wr32(OFS_MASK, 32'h0000_0FFC);
   endtask

   // Edge inputs latch a pulse, level inputs do not
   task automatic t_sense();
      wr32(OFS_GIE, 32'h0000_0002);
      wr32(OFS_CTRL, 32'h0000_0002);
      @(posedge clk);
      pins.edge_level_irq_a_n <= 1'b0;
      pins.level_irq_b_n <= 1'b0;
      pins.edge_irq_forceable_n <= 1'b0;
      repeat (4) @(posedge clk);
      pins <= 7'h7F;
      repeat (4) @(posedge clk);
      wr32(OFS_FC, 32'h0080_0000);
      wr32(OFS_GIE, 32'h0000_0001);
      serve(14'h0004, 1'b1);
      quiet(10);
   endtask

   task automatic t_nest();
      wr32(OFS_CTRL, 32'h0000_0001);
      dly <= 8'h03;
      wr32(OFS_FC, 32'h0000_0800);
      serve(14'h0028, 1'b0);
      @(posedge clk);
      pins.level_irq_b_n <= 1'b0;
      serve(14'h000C, 1'b0);
      @(posedge clk);
      pins.level_irq_b_n <= 1'b1;
      rd32(OFS_STAT, rv);
      chk({23'h00_0000, rv[20:12]}, 32'h0000_0024, "nested level");
      pop();
      pop();
      dly <= 8'h00;
      wr32(OFS_CTRL, 32'h0000_0000);
      wr32(OFS_FC, 32'h0000_0800);
      serve(14'h0028, 1'b0);
      wr32(OFS_FC, 32'h0000_0010);
      quiet(8);
      pop();
      serve(14'h000C, 1'b1);
   endtask

   // Serial port one pins reused as interrupts and flags
   task automatic t_alt();
      wr32(OFS_CTRL, 32'h0000_0050);
      @(posedge clk);
      pins.flag_input_alt <= 1'b0;
      pins.alt_irq_tx_n <= 1'b0;
      #1 chk({31'h0000_0000, flag_out}, 32'h0000_0001, "flag out");
      serve(14'h0020, 1'b0);
      @(posedge clk);
      pins.alt_irq_tx_n <= 1'b1;
      pins.alt_irq_rx_n <= 1'b0;
      pop();
      serve(14'h0024, 1'b0);
      @(posedge clk);
      pins.alt_irq_rx_n <= 1'b1;
      rd32(OFS_STAT, rv);
      chk({31'h0000_0000, rv[21]}, 32'h0000_0000, "flag in");
      pop();
      // Both alternate pins in edge mode: a one-cycle pulse is latched
      wr32(OFS_CTRL, 32'h0000_001C);
      @(posedge clk);
      pins.alt_irq_rx_n <= 1'b0;
      @(posedge clk);
      pins.alt_irq_rx_n <= 1'b1;
      serve(14'h0024, 1'b1);
      wr32(OFS_CTRL, 32'h0000_0000);
      ev(1);
      serve(14'h0024, 1'b1);
      @(posedge clk);
      pins.flag_input_alt <= 1'b1;
   endtask

   // Power-up context reset overrides global disable
   task automatic t_pwrup();
      wr32(OFS_CTRL, 32'h0000_0020);
      wr32(OFS_GIE, 32'h0000_0002);
      ev(7);
      serve(14'h0000, 1'b1);
      wr32(OFS_GIE, 32'h0000_0001);
   endtask

   task automatic print_verdict();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_prio();
      t_mask();
      t_gie();
      t_sense();
      t_nest();
      t_alt();
      t_pwrup();
      print_verdict();
   end

   // Watchdog, well above the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      print_verdict();
   end
endmodule
